// ==== common/hpprc_defines.svh ====
// Timing counts and fixed values for the hub port power and reset control
// Included by the design files; assumes a 20 MHz clock (50 ns period)
`ifndef HPPRC_DEFINES_SVH
`define HPPRC_DEFINES_SVH

`define HPPRC_CLK_PERIOD_NS     50
`define HPPRC_NUM_PORTS         4
// Power-on hold time, in microseconds
`define HPPRC_POR_HOLD_US       1000
`define HPPRC_POR_CYCLES        ((`HPPRC_POR_HOLD_US * 1000 + `HPPRC_CLK_PERIOD_NS - 1) / `HPPRC_CLK_PERIOD_NS)
// Over-current filter time, in nanoseconds
`define HPPRC_OC_FILTER_NS      1000
`define HPPRC_OC_FILTER_CYCLES  ((`HPPRC_OC_FILTER_NS + `HPPRC_CLK_PERIOD_NS - 1) / `HPPRC_CLK_PERIOD_NS)
`define HPPRC_OC_CNT_W          8
`define HPPRC_ADDR_DEFAULT      7'h00

`endif

// ==== common/hpprc_pkg.sv ====
// Types for the hub port power and reset control
// Assumes nothing beyond a SystemVerilog compiler
package hpprc_pkg;
   typedef enum logic [1:0] {
      HPPRC_UNCONFIGURED,
      HPPRC_CONFIGURED,
      HPPRC_SUSPENDED
   } hpprc_dev_state_e;
   typedef logic [6:0] hpprc_addr_t;
endpackage

// ==== src/hpprc_oc_filter.sv ====
// One port's over-current sense path: synchroniser and low-level filter
// Assumes the pin level arrives asynchronously from the board
`timescale 1ns/10ps
`include "hpprc_defines.svh"
module hpprc_oc_filter
   import hpprc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Pin level and qualifiers
   input  wire logic senseIn,
   input  wire logic powerOn,
   // Filtered result
   output logic      overCurrent
);
   logic                       syncA;
   logic                       syncB;
   logic [`HPPRC_OC_CNT_W-1:0] lowCount;
   logic [`HPPRC_OC_CNT_W-1:0] next_lowCount;
   logic                       next_overCurrent;

   localparam logic [`HPPRC_OC_CNT_W-1:0] FILT = `HPPRC_OC_CNT_W'(`HPPRC_OC_FILTER_CYCLES);

   // Count consecutive lows; any high restarts so power-up dips are ignored
   always_comb begin
      next_lowCount    = lowCount;
      next_overCurrent = overCurrent;
      if (!powerOn) begin
         next_lowCount    = '0;
         next_overCurrent = 1'b0;
      end else if (syncB) begin
         next_lowCount    = '0;
         next_overCurrent = 1'b0;
      end else if (lowCount < FILT) begin
         next_lowCount = lowCount + 8'h01;
      end else begin
         next_overCurrent = 1'b1;
      end
   end

   // Two flops before the filter reads the pin
   always_ff @(posedge clk) begin
      if (reset) begin
         syncA       <= 1'b1;
         syncB       <= 1'b1;
         lowCount    <= '0;
         overCurrent <= 1'b0;
      end else begin
         syncA       <= senseIn;
         syncB       <= syncA;
         lowCount    <= next_lowCount;
         overCurrent <= next_overCurrent;
      end
   end

   AST_OC_NEEDS_POWER: assert property (@(posedge clk) disable iff (reset)
      overCurrent |-> $past(powerOn)) else $error("over-current flagged on unpowered port");
   AST_OC_FILTERED: assert property (@(posedge clk) disable iff (reset)
      $rose(overCurrent) |-> $past(!syncB, 1) && $past(!syncB, 2)) else $error("over-current without filtered low");
endmodule // hpprc_oc_filter

// ==== src/hpprc_ctrl.sv ====
// Hub port power drive, over-current sense and chip-level reset control
// Assumes one 20 MHz clock; pins pass through pad cells that honour oe/pull controls
//
// Function
// - Each downstream port has one pin for power control and over-current sense.
// - Port power off: drive pin low, pull-up off.
// - Port power on: driver off, pull-up on, pin is open drain.
// - Low on an enabled port's pin means over-current.
// - Filter sense input so transient lows do not flag over-current.
// - Poly fuse uses same pin behaviour; opened fuse reads low as over-current.
// - Reset sources: power-on, external reset pin, upstream bus reset.
// - Internal timer holds reset after power is applied.
// - External reset held: stay in low-current standby.
// - External reset disables transceiver, pairs high impedance.
// - External reset ends all transactions without keeping state.
// - External reset returns all registers to defaults.
// - External reset stops oscillator and PLL.
// - Bus reset sets bus address to zero.
// - Bus reset returns device to unconfigured.
// - Bus reset wakes a suspended device.
// - Bus reset is not passed to downstream ports.
`timescale 1ns/10ps
`include "hpprc_defines.svh"
module hpprc_ctrl
   import hpprc_pkg::*;
#(
   parameter int POR_CYCLES = `HPPRC_POR_CYCLES
) (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         reset,
   // Reset sources
   input  wire logic                         extReset_n,
   input  wire logic                         busResetReq,
   // Hub core requests
   input  wire logic [`HPPRC_NUM_PORTS-1:0]  portPowerReq,
   input  wire logic                         setAddrValid,
   input  wire hpprc_addr_t                  setAddr,
   input  wire logic                         setConfigReq,
   input  wire logic                         suspendReq,
   // Port power and sense pins
   input  wire logic [`HPPRC_NUM_PORTS-1:0]  portPowerSensePinIn,
   output logic [`HPPRC_NUM_PORTS-1:0]       portPowerSensePinOut,
   output logic [`HPPRC_NUM_PORTS-1:0]       portPowerSensePinOe_n,
   output logic [`HPPRC_NUM_PORTS-1:0]       portPullUpEn,
   // Over-current status
   output logic [`HPPRC_NUM_PORTS-1:0]       overcurrentSenseSignal,
   // Chip reset and power controls
   output logic                              chipReset,
   output logic                              standby,
   output logic                              phyEnable,
   output logic                              oscEnable,
   output logic                              pllEnable,
   output logic                              downstreamReset,
   output logic                              transactionAbort,
   // Device state
   output hpprc_addr_t                       busAddr,
   output hpprc_dev_state_e                  devState
);
   localparam int PW = 32;

   // Latency from each source, in clk edges:
   //   extReset_n low  -> standby, oscEnable and pllEnable follow after 2 edges, chipReset after 3
   //   extReset_n high -> the same path back; chipReset drops only once the power-on timer is done
   //   reset released  -> chipReset held for POR_CYCLES edges plus one of pipeline
   //   busResetReq     -> busAddr and devState back to defaults on the next edge
   //   portPowerReq    -> pin drive and pull-up follow on the next edge
   // chipReset is registered so every consumer leaves reset on one clean edge; the price
   // is a cycle in which standby is already up while the transceiver still runs.

   logic                         extSyncA;
   logic                         extSyncB;
   logic [PW-1:0]                porCount;
   logic [PW-1:0]                next_porCount;
   logic                         porActive;
   logic                         next_porActive;
   logic                         next_chipReset;
   logic [`HPPRC_NUM_PORTS-1:0]  portOn;
   logic [`HPPRC_NUM_PORTS-1:0]  next_portOn;
   hpprc_addr_t                  next_busAddr;
   hpprc_dev_state_e             next_devState;
   logic                         extHeld;

   // Power-on counter runs from the block's own reset (standing in for power arrival)
   always_comb begin
      next_porCount  = porCount;
      next_porActive = porActive;
      if (porActive) begin
         if (porCount >= POR_CYCLES[PW-1:0] - 32'h00000001) begin
            next_porActive = 1'b0;
         end else begin
            next_porCount = porCount + 32'h00000001;
         end
      end
   end

   // External pin is asynchronous, so synchronise before use
   assign extHeld = !extSyncB;

   // Combine sources into one clock-aligned internal reset
   always_comb begin
      next_chipReset = porActive || extHeld;
   end

   // Sync flops reset to the held level, so the pin cannot free the chip in the first two edges
   always_ff @(posedge clk) begin
      if (reset) begin
         extSyncA  <= 1'b0;
         extSyncB  <= 1'b0;
         porCount  <= '0;
         porActive <= 1'b1;
         chipReset <= 1'b1;
      end else begin
         extSyncA  <= extReset_n;
         extSyncB  <= extSyncA;
         porCount  <= next_porCount;
         porActive <= next_porActive;
         chipReset <= next_chipReset;
      end
   end

   // Standby outputs follow the external pin; clocks halt while it is held
   always_comb begin
      standby          = extHeld;
      phyEnable        = !chipReset;
      oscEnable        = !extHeld;
      pllEnable        = !extHeld;
      transactionAbort = chipReset;
      downstreamReset  = chipReset;     // bus reset deliberately excluded
   end

   // Port power state; cleared on any chip reset
   // Bus reset stays out of this path on purpose: downstream devices keep their power
   always_comb begin
      next_portOn = chipReset ? '0 : portPowerReq;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         portOn <= '0;
      end else begin
         portOn <= next_portOn;
      end
   end

   // Pin drive: low with pull-up off when off, released with pull-up when on
   always_comb begin
      portPowerSensePinOut  = '0;
      portPowerSensePinOe_n = portOn;
      portPullUpEn          = portOn;
   end

   // One sense filter per port
   // Filter also sees chipReset, so a trip never outlives a chip reset
   for (genvar p = 0; p < `HPPRC_NUM_PORTS; p++) begin : g_port
      hpprc_oc_filter u_filt (
         .clk         (clk),
         .reset       (reset || chipReset),
         .senseIn     (portPowerSensePinIn[p]),
         .powerOn     (portOn[p]),
         .overCurrent (overcurrentSenseSignal[p])
      );
   end

   // Address and configuration; bus reset has priority over core requests
   // SUSPENDED is left only through a bus or chip reset; this block has no resume path
   always_comb begin
      next_busAddr  = busAddr;
      next_devState = devState;
      if (chipReset) begin
         next_busAddr  = `HPPRC_ADDR_DEFAULT;
         next_devState = HPPRC_UNCONFIGURED;
      end else if (busResetReq) begin
         next_busAddr  = `HPPRC_ADDR_DEFAULT;
         next_devState = HPPRC_UNCONFIGURED;
      end else begin
         if (setAddrValid) begin
            next_busAddr = setAddr;
         end
         case (devState)
            HPPRC_UNCONFIGURED: begin
               if (suspendReq) next_devState = HPPRC_SUSPENDED;
               else if (setConfigReq) next_devState = HPPRC_CONFIGURED;
            end
            HPPRC_CONFIGURED: begin
               if (suspendReq) next_devState = HPPRC_SUSPENDED;
            end
            HPPRC_SUSPENDED: begin
               next_devState = HPPRC_SUSPENDED;
            end
            default: next_devState = HPPRC_UNCONFIGURED;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busAddr  <= `HPPRC_ADDR_DEFAULT;
         devState <= HPPRC_UNCONFIGURED;
      end else begin
         busAddr  <= next_busAddr;
         devState <= next_devState;
      end
   end

   // Checks
   sequence busResetSeen;
      busResetReq && !chipReset;
   endsequence
   // Pin low long enough for both sync flops and the reset register to follow
   sequence extPinHeld;
      !extReset_n [*4];
   endsequence
   // Pin back high through the synchroniser with the power-on timer already done
   sequence extPinFreed;
      extReset_n [*4] ##0 !porActive;
   endsequence
   // A bus reset that lands while the hub is suspended
   sequence busResetWhileAsleep;
      busResetSeen ##0 devState == HPPRC_SUSPENDED;
   endsequence

   AST_PIN_OFF_DRIVES_LOW: assert property (@(posedge clk) disable iff (reset)
      !portOn[0] |-> !portPowerSensePinOe_n[0] && !portPullUpEn[0]) else $error("off port not driven low");
   AST_PIN_ON_OPEN_DRAIN: assert property (@(posedge clk) disable iff (reset)
      portPowerReq[0] && !chipReset |=> portPowerSensePinOe_n[0] && portPullUpEn[0]) else $error("on port not released");
   AST_PINS_SHARED: assert property (@(posedge clk) disable iff (reset)
      portPowerSensePinOe_n == portPullUpEn) else $error("drive and pull-up disagree");
   AST_POR_HOLD: assert property (@(posedge clk)
      $fell(reset) |-> chipReset [*8]) else $error("power-on reset released early");
   AST_EXT_STANDBY: assert property (@(posedge clk) disable iff (reset)
      extPinHeld |-> standby && !oscEnable && !pllEnable && !phyEnable) else $error("standby not entered");
   AST_EXT_DEFAULTS: assert property (@(posedge clk) disable iff (reset)
      chipReset |=> busAddr == `HPPRC_ADDR_DEFAULT && devState == HPPRC_UNCONFIGURED && portOn == '0) else $error("registers not defaulted");
   AST_BUS_RESET: assert property (@(posedge clk) disable iff (reset)
      busResetSeen |=> busAddr == `HPPRC_ADDR_DEFAULT && devState == HPPRC_UNCONFIGURED) else $error("bus reset ignored");
   AST_NO_PROPAGATE: assert property (@(posedge clk) disable iff (reset)
      busResetSeen |-> !downstreamReset) else $error("bus reset propagated");

   // External pin, standby and the internal reset
   AST_EXT_PHY_OFF: assert property (@(posedge clk) disable iff (reset)
      extPinHeld |-> !phyEnable && transactionAbort)
      else $error("transceiver live during external reset");
   AST_EXT_RUNNING: assert property (@(posedge clk) disable iff (reset)
      extReset_n [*3] |-> !standby && oscEnable && pllEnable)
      else $error("standby kept after external reset release");
   AST_STANDBY_LEADS: assert property (@(posedge clk) disable iff (reset)
      standby |=> chipReset)
      else $error("standby without internal reset");
   AST_RESET_RELEASE: assert property (@(posedge clk) disable iff (reset)
      extPinFreed |=> !chipReset)
      else $error("internal reset stuck after release");

   // Power-on timer
   AST_POR_ONCE: assert property (@(posedge clk) disable iff (reset)
      !porActive |=> !porActive)
      else $error("power-on timer restarted without power loss");
   AST_POR_BOUND: assert property (@(posedge clk) disable iff (reset)
      porActive |-> porCount < POR_CYCLES[PW-1:0])
      else $error("power-on timer ran past its limit");

   // Bus reset and device state
   AST_BUS_WAKE: assert property (@(posedge clk) disable iff (reset)
      busResetWhileAsleep |=> devState == HPPRC_UNCONFIGURED)
      else $error("bus reset left hub suspended");
   AST_BUS_ADDR_FIRST: assert property (@(posedge clk) disable iff (reset)
      busResetSeen ##0 setAddrValid |=> busAddr == `HPPRC_ADDR_DEFAULT)
      else $error("address load beat bus reset");
   AST_BUS_KEEPS_POWER: assert property (@(posedge clk) disable iff (reset)
      busResetSeen |=> portPowerSensePinOe_n == $past(portPowerReq))
      else $error("bus reset disturbed port power");
   AST_CONFIG_STEP: assert property (@(posedge clk) disable iff (reset)
      devState == HPPRC_UNCONFIGURED && setConfigReq && !suspendReq && !busResetReq && !chipReset
      |=> devState == HPPRC_CONFIGURED)
      else $error("host configuration not taken");

   // Every port keeps the pin rules, not only port 0
   for (genvar q = 0; q < `HPPRC_NUM_PORTS; q++) begin : g_chk
      AST_PORT_OFF_LOW: assert property (@(posedge clk) disable iff (reset)
         !portOn[q] |-> !portPowerSensePinOut[q] && !portPowerSensePinOe_n[q] && !portPullUpEn[q])
         else $error("port pin not driven low while off");
      AST_PORT_ON_OPEN: assert property (@(posedge clk) disable iff (reset)
         portPowerReq[q] && !chipReset |=> portPowerSensePinOe_n[q] && portPullUpEn[q])
         else $error("port pin not released while on");
      AST_PORT_RESET_OFF: assert property (@(posedge clk) disable iff (reset)
         chipReset |=> !portPowerSensePinOe_n[q] && !portPullUpEn[q])
         else $error("port powered during chip reset");
      AST_PORT_OC_POWERED: assert property (@(posedge clk) disable iff (reset)
         !portOn[q] |=> !overcurrentSenseSignal[q])
         else $error("over-current kept on an unpowered port");
      AST_PORT_OC_SETTLE: assert property (@(posedge clk) disable iff (reset)
         $rose(portOn[q]) |-> !overcurrentSenseSignal[q] [*8])
         else $error("over-current flagged during power-up dip");
   end
endmodule // hpprc_ctrl

// ==== verification/hpprc_switch_model.sv ====
// Board model of the per-port power switch or poly fuse on each shared pin
// Assumes the bench raises fault to mimic a tripped switch or an opened fuse
`timescale 1ns/10ps
`include "hpprc_defines.svh"
module hpprc_switch_model
   import hpprc_pkg::*;
(
   // Hub side of the pins
   input  wire logic [`HPPRC_NUM_PORTS-1:0] pinOut,
   input  wire logic [`HPPRC_NUM_PORTS-1:0] pinOe_n,
   input  wire logic [`HPPRC_NUM_PORTS-1:0] pullUpEn,
   // Fault injection per port
   input  wire logic [`HPPRC_NUM_PORTS-1:0] fault,
   // Resolved wire level
   output logic      [`HPPRC_NUM_PORTS-1:0] pinLevel
);
   // Driver wins when enabled; released pin sits on the pull-up unless the switch or fuse pulls it down
   // No keeper exists, so a released pin with the pull-up off reads low and shows up as a false trip
   always_comb begin
      for (int p = 0; p < `HPPRC_NUM_PORTS; p++) begin
         pinLevel[p] = pinOe_n[p] ? (pullUpEn[p] & ~fault[p]) : pinOut[p];
      end
   end
endmodule // hpprc_switch_model

// ==== verification/tb.sv ====
// Self-checking bench for the port power and chip reset control
// Assumes hpprc_switch_model sits on the pins; the bench acts as hub core and upstream host
`timescale 1ns/10ps
`include "hpprc_defines.svh"
module tb
   import hpprc_pkg::*;
();
   localparam int POR = 16;
   localparam int NP  = `HPPRC_NUM_PORTS;
   // Stimulus and observed signals
   logic             clk, reset, extReset_n, busResetReq, setAddrValid, setConfigReq, suspendReq;
   logic [NP-1:0]    portPowerReq, fault, pinIn, pinOut, pinOe_n, pullUp, oc;
   hpprc_addr_t      setAddr, busAddr;
   hpprc_dev_state_e devState;
   logic             chipReset, standby, phyEnable, oscEnable, pllEnable, downstreamReset, transactionAbort;
   int               failures, n_tests;

   hpprc_ctrl #(.POR_CYCLES(POR)) hpprc_ctrl_inst (
      .clk(clk), .reset(reset), .extReset_n(extReset_n), .busResetReq(busResetReq),
      .portPowerReq(portPowerReq), .setAddrValid(setAddrValid), .setAddr(setAddr),
      .setConfigReq(setConfigReq), .suspendReq(suspendReq), .portPowerSensePinIn(pinIn),
      .portPowerSensePinOut(pinOut), .portPowerSensePinOe_n(pinOe_n), .portPullUpEn(pullUp),
      .overcurrentSenseSignal(oc), .chipReset(chipReset), .standby(standby), .phyEnable(phyEnable),
      .oscEnable(oscEnable), .pllEnable(pllEnable), .downstreamReset(downstreamReset),
      .transactionAbort(transactionAbort), .busAddr(busAddr), .devState(devState));
   hpprc_switch_model hpprc_switch_model_inst (
      .pinOut(pinOut), .pinOe_n(pinOe_n), .pullUpEn(pullUp), .fault(fault), .pinLevel(pinIn));

   // 20 MHz clock
   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   // Inputs move on falling edges only, so the design never samples a changing value
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic close_out;
      $display("Counts: %0d compares, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for the internal reset to drop
   task automatic wait_run(input int lim);
      int k;
      k = 0;
      while (chipReset !== 1'b0 && k < lim) begin
         cyc(1);
         k++;
      end
      if (chipReset !== 1'b0) begin
         failures++;
         $display("MISMATCH t=%0t internal reset never released", $time);
         close_out();
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask

   task automatic t_por;
      chk(chipReset, 1'b1, "reset held");
      chk(pinOe_n, '0, "ports driven low in reset");
      chk(pullUp, '0, "pull-ups off in reset");
      chk(busAddr, 7'h00, "address in reset");
      reset = 1'b0;
      cyc(POR - 2);
      chk(chipReset, 1'b1, "power-on hold too short");
      chk(pinOe_n, '0, "ports stay off during hold");
      wait_run(8);
      $display("test por done");
   endtask

   task automatic t_ports;
      portPowerReq = 4'hF;
      cyc(2);
      chk(pinOe_n, 4'hF, "drivers released");
      chk(pullUp, 4'hF, "pull-ups on");
      chk(pinOut, 4'h0, "drive value low");
      chk(oc, 4'h0, "no trip on healthy pins");
      portPowerReq = 4'h5;
      cyc(2);
      chk(pinOe_n, 4'h5, "off ports driven");
      chk(pullUp, 4'h5, "off ports pull-up off");
      portPowerReq = 4'hF;
      cyc(2);
      $display("test ports done");
   endtask

   task automatic t_oc;
      fault = 4'h1;
      cyc(10);
      fault = 4'h0;
      cyc(3);
      chk(oc, 4'h0, "short low filtered");
      fault = 4'h1;
      cyc(30);
      chk(oc, 4'h1, "sustained low trips one port only");
      fault = 4'h0;
      cyc(3);
      chk(oc, 4'h0, "trip clears on high");
      fault = 4'h2;
      cyc(30);
      chk(oc, 4'h2, "second port trips");
      portPowerReq = 4'hD;
      cyc(3);
      chk(oc, 4'h0, "port off ignores low");
      fault = 4'h0;
      portPowerReq = 4'hF;
      cyc(2);
      $display("test overcurrent done");
   endtask

   task automatic t_bus;
      setAddr = 7'h2A;
      pulse(setAddrValid);
      pulse(setConfigReq);
      pulse(suspendReq);
      cyc(1);
      chk(busAddr, 7'h2A, "address loaded");
      chk(devState, HPPRC_SUSPENDED, "suspended");
      setAddr = 7'h33;
      setAddrValid = 1'b1;
      busResetReq = 1'b1;
      cyc(1);
      chk(downstreamReset, 1'b0, "bus reset kept upstream");
      setAddrValid = 1'b0;
      busResetReq = 1'b0;
      cyc(1);
      chk(busAddr, 7'h00, "address cleared");
      chk(devState, HPPRC_UNCONFIGURED, "woken unconfigured");
      chk(pinOe_n, 4'hF, "downstream power untouched");
      pulse(setConfigReq);
      cyc(1);
      chk(devState, HPPRC_CONFIGURED, "configured again");
      $display("test bus reset done");
   endtask

   task automatic t_ext;
      setAddr = 7'h11;
      pulse(setAddrValid);
      extReset_n = 1'b0;
      cyc(4);
      chk(standby, 1'b1, "standby");
      chk(phyEnable, 1'b0, "transceiver off");
      chk(transactionAbort, 1'b1, "transfers cut");
      chk({oscEnable, pllEnable}, 2'b00, "clocks halted");
      chk(busAddr, 7'h00, "address default");
      chk(devState, HPPRC_UNCONFIGURED, "state default");
      chk(pinOe_n, 4'h0, "ports default off");
      cyc(100);
      extReset_n = 1'b1;
      wait_run(POR + 8);
      chk({standby, phyEnable, oscEnable, pllEnable}, 4'h7, "running again");
      chk(transactionAbort, 1'b0, "transfers allowed");
      cyc(2);
      chk(pinOe_n, 4'hF, "all ports leave reset together");
      $display("test external reset done");
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("MISMATCH t=%0t run timed out", $time);
      close_out();
   end

   // Main sequence
   initial begin
      {clk, busResetReq, setAddrValid, setConfigReq, suspendReq} = '0;
      {portPowerReq, fault, setAddr} = '0;
      {failures, n_tests} = '0;
      reset = 1'b1;
      extReset_n = 1'b1;
      cyc(5);
      t_por();
      t_ports();
      t_oc();
      t_bus();
      t_ext();
      close_out();
   end
endmodule // tb
